/* hw/pmr_pkg.sv */
package pmr_pkg;
    // Register offsets
    localparam logic [11:0] OFS_START      = 12'h000;
    localparam logic [11:0] OFS_STOP       = 12'h004;
    localparam logic [11:0] OFS_SUB_START  = 12'h080;
    localparam logic [11:0] OFS_SUB_STOP   = 12'h084;
    localparam logic [11:0] OFS_EV_RUN     = 12'h100;
    localparam logic [11:0] OFS_EV_HALT    = 12'h104;
    localparam logic [11:0] OFS_EV_DONE    = 12'h108;
    localparam logic [11:0] OFS_PUB_RUN    = 12'h180;
    localparam logic [11:0] OFS_PUB_HALT   = 12'h184;
    localparam logic [11:0] OFS_PUB_DONE   = 12'h188;
    localparam logic [11:0] OFS_IRQ_EN     = 12'h300;
    localparam logic [11:0] OFS_IRQ_SET    = 12'h304;
    localparam logic [11:0] OFS_IRQ_CLR    = 12'h308;
    localparam logic [11:0] OFS_ENABLE     = 12'h500;
    localparam logic [11:0] OFS_CLKDIV     = 12'h504;
    localparam logic [11:0] OFS_MODE       = 12'h508;
    localparam logic [11:0] OFS_GAIN_L     = 12'h518;
    localparam logic [11:0] OFS_GAIN_R     = 12'h51c;
    localparam logic [11:0] OFS_RATIO      = 12'h520;
    localparam logic [11:0] OFS_BUF_PTR    = 12'h560;
    localparam logic [11:0] OFS_BUF_CNT    = 12'h564;
    // Field positions and widths
    localparam int          CFG_EN_BIT     = 31;
    localparam int          EVENT_CHANNEL_INDEX_W        = 4;
    localparam int          IRQ_RUN_BIT    = 0;
    localparam int          IRQ_HALT_BIT   = 1;
    localparam int          IRQ_DONE_BIT   = 2;
    localparam int          MODE_MONO_BIT  = 0;
    localparam int          MODE_EDGE_BIT  = 1;
    localparam int          GAIN_W         = 7;
    localparam int          CNT_W          = 15;
    // Reset values and gain limits
    localparam logic [31:0] CLKDIV_RST     = 32'h0840_0000;
    localparam logic [6:0]  GAIN_UNITY     = 7'h28;
    localparam logic [6:0]  GAIN_CEILING   = 7'h50;
    localparam logic [6:0]  GAIN_FLOOR     = 7'h00;
    // Divider: frequency = 32 MHz * setting / 2^32, system clock at 50 MHz
    localparam int          SRC_MHZ        = 32;
    localparam int          SYS_MHZ        = 50;
    localparam int          RATIO_64       = 64;
    localparam int          RATIO_80       = 80;
    typedef enum logic [1:0] {PMR_IDLE, PMR_RUN, PMR_DRAIN} pmr_state_t;
endpackage : pmr_pkg

/* hw/pmr_regs.sv */
`timescale 1ns/1ps
module pmr_regs
    import pmr_pkg::*;
#(
    parameter int CH_N = 16
)(
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic [11:0]             addr,
    input  wire logic [31:0]             wdata,
    input  wire logic                    wr_stb,
    input  wire logic                    rd_stb,
    output logic      [31:0]             rdata,
    input  wire logic [CH_N-1:0]         chan_in,
    output logic      [CH_N-1:0]         chan_out,
    output logic                         irq,
    output logic                         mic_clock,
    input  wire logic                    mic_data,
    output logic                         mem_we,
    output logic      [31:0]             mem_addr,
    output logic      [31:0]             mem_wdata
);
    import pmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic                   rs1_ff, rst_sync_b;
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b) {rst_sync_b, rs1_ff} <= 2'b00;
        else        {rst_sync_b, rs1_ff} <= {rs1_ff, 1'b1};
    end

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [6:0] clamp_gain(input logic [31:0] v);
        clamp_gain = (v > {25'd0, GAIN_CEILING}) ? GAIN_CEILING : v[6:0];
    endfunction : clamp_gain

    function automatic logic [31:0] cfg_word(input logic en, input logic [3:0] ch);
        cfg_word = {en, 27'd0, ch};
    endfunction : cfg_word

    logic [2:0]   ev_ff, nxt_ev;
    logic [2:0]   ien_ff;
    logic [3:0]   pch_ff [3];
    logic [2:0]   pen_ff;
    logic [3:0]   sch_ff [2];
    logic [1:0]   sen_ff;
    logic         enable_ff;
    logic [31:0]  div_ff;
    logic [1:0]   mode_ff;
    logic [6:0]   gl_ff, gr_ff;
    logic         ratio_ff;
    logic [31:0]  ptr_ff, ptr_act_ff;
    logic [14:0]  cnt_ff;
    logic [31:0]  rdata_ff;
    logic         irq_ff;
    logic [CH_N-1:0] chan_ff;

    wire wr = wr_stb;
    wire w_start = wr && addr == OFS_START && wdata[0];
    wire w_stop  = wr && addr == OFS_STOP  && wdata[0];
    wire s_start = sen_ff[0] && chan_in[sch_ff[0]];
    wire s_stop  = sen_ff[1] && chan_in[sch_ff[1]];
    wire go      = (w_start || s_start) && enable_ff;
    wire halt    = w_stop || s_stop;

    ////////////////////////////////////////////////////////////////////////
    // Mic clock: phase accumulator at SRC_MHZ/SYS_MHZ scale
    logic [31:0]  acc_ff;
    logic         mclk_ff;
    // Two half-period ticks per mic clock period
    wire  [31:0]  step = 32'((64'(div_ff) * (2 * SRC_MHZ)) / SYS_MHZ);
    wire  [32:0]  acc_sum = {1'b0, acc_ff} + {1'b0, step};
    wire          half_tick = acc_sum[32];
    wire          rise = half_tick && !mclk_ff;
    wire          fall = half_tick &&  mclk_ff;
    pmr_state_t   st_ff;

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            acc_ff  <= 32'h0000_0000;
            mclk_ff <= 1'b0;
        end
        else if (enable_ff && st_ff != PMR_IDLE)
        begin
            acc_ff <= acc_sum[31:0];
            if (half_tick)
                mclk_ff <= !mclk_ff;
        end
        else
            mclk_ff <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sampling and simple decimation (bit count per output frame)
    // edge selection
    wire left_edge  = mode_ff[MODE_EDGE_BIT] ? rise : fall;
    wire right_edge = mode_ff[MODE_EDGE_BIT] ? fall : rise;
    logic [6:0]   dec_ff;
    logic [7:0]   sum_l_ff, sum_r_ff;
    logic         hold_ff;
    logic [15:0]  lo_ff;
    logic [14:0]  done_ff;
    wire  [6:0]   dec_top = ratio_ff ? 7'(RATIO_80 - 1) : 7'(RATIO_64 - 1);
    wire          frame = rise && dec_ff == dec_top;
    wire  [15:0]  s_l = 16'(sum_l_ff * gl_ff);
    wire  [15:0]  s_r = 16'(sum_r_ff * gr_ff);
    wire          mono = mode_ff[MODE_MONO_BIT];
    wire          word_rdy = frame && (!mono || hold_ff);
    // Every word holds two samples, stereo and mono alike
    wire  [14:0]  done_n = 15'(done_ff + 15'd2);
    wire          last   = word_rdy && done_n >= cnt_ff;

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            dec_ff   <= 7'd0;
            sum_l_ff <= 8'd0;
            sum_r_ff <= 8'd0;
            hold_ff  <= 1'b0;
            lo_ff    <= 16'h0000;
        end
        else if (st_ff == PMR_IDLE)
        begin
            dec_ff   <= 7'd0;
            sum_l_ff <= 8'd0;
            sum_r_ff <= 8'd0;
            hold_ff  <= 1'b0;
        end
        else
        begin
            if (rise) dec_ff <= frame ? 7'd0 : 7'(dec_ff + 7'd1);
            if (frame)
            begin
                sum_l_ff <= 8'd0;
                sum_r_ff <= 8'd0;
                if (mono) hold_ff <= !hold_ff;
                lo_ff <= s_l;
            end
            else
            begin
                if (left_edge && mic_data)  sum_l_ff <= 8'(sum_l_ff + 8'd1);
                if (right_edge && mic_data) sum_r_ff <= 8'(sum_r_ff + 8'd1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencing
    wire ev_run  = (st_ff == PMR_IDLE && go) || (st_ff == PMR_RUN && last && !halt);
    wire ev_done = (st_ff != PMR_IDLE) && (last || (st_ff == PMR_DRAIN && word_rdy));
    wire ev_halt = st_ff == PMR_DRAIN && ev_done;

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            st_ff      <= PMR_IDLE;
            ptr_act_ff <= 32'h0000_0000;
            done_ff    <= 15'd0;
            mem_we     <= 1'b0;
            mem_addr   <= 32'h0000_0000;
            mem_wdata  <= 32'h0000_0000;
        end
        else
        begin
            // No memory write once disabled: the transfer is aborted
            mem_we <= word_rdy && st_ff != PMR_IDLE && enable_ff;
            if (word_rdy)
            begin
                mem_addr <= ptr_act_ff + {15'd0, done_ff, 2'b00} / 32'd2;
                mem_wdata <= mono ? {s_l, lo_ff} : {s_r, s_l};
                done_ff <= done_n;
            end
            case (st_ff)
                PMR_IDLE:
                    if (go)
                    begin
                        st_ff      <= PMR_RUN;
                        ptr_act_ff <= ptr_ff;
                        done_ff    <= 15'd0;
                    end
                PMR_RUN:
                    if (halt) st_ff <= PMR_DRAIN;
                    else if (last)
                    begin
                        ptr_act_ff <= ptr_ff;
                        done_ff    <= 15'd0;
                    end
                PMR_DRAIN:
                    if (word_rdy) st_ff <= PMR_IDLE;
                default: st_ff <= PMR_IDLE;
            endcase
            if (!enable_ff) st_ff <= PMR_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register writes
    wire [2:0] ev_set = {ev_done, ev_halt, ev_run};
    always_comb
    begin
        nxt_ev = ev_ff;
        if (wr && addr == OFS_EV_RUN)  nxt_ev[0] = wdata[0];
        if (wr && addr == OFS_EV_HALT) nxt_ev[1] = wdata[0];
        if (wr && addr == OFS_EV_DONE) nxt_ev[2] = wdata[0];
        nxt_ev = nxt_ev | ev_set;
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            ev_ff     <= 3'b000;
            ien_ff    <= 3'b000;
            pen_ff    <= 3'b000;
            sen_ff    <= 2'b00;
            pch_ff    <= '{default: 4'h0};
            sch_ff    <= '{default: 4'h0};
            enable_ff <= 1'b0;
            div_ff    <= CLKDIV_RST;
            mode_ff   <= 2'b00;
            gl_ff     <= GAIN_UNITY;
            gr_ff     <= GAIN_UNITY;
            ratio_ff  <= 1'b0;
            ptr_ff    <= 32'h0000_0000;
            cnt_ff    <= 15'd0;
        end
        else
        begin
            ev_ff <= nxt_ev;
            if (wr)
                case (addr)
                    OFS_SUB_START: {sen_ff[0], sch_ff[0]} <= {wdata[CFG_EN_BIT], wdata[3:0]};
                    OFS_SUB_STOP:  {sen_ff[1], sch_ff[1]} <= {wdata[CFG_EN_BIT], wdata[3:0]};
                    OFS_PUB_RUN:   {pen_ff[0], pch_ff[0]} <= {wdata[CFG_EN_BIT], wdata[3:0]};
                    OFS_PUB_HALT:  {pen_ff[1], pch_ff[1]} <= {wdata[CFG_EN_BIT], wdata[3:0]};
                    OFS_PUB_DONE:  {pen_ff[2], pch_ff[2]} <= {wdata[CFG_EN_BIT], wdata[3:0]};
                    OFS_IRQ_EN:    ien_ff <= wdata[2:0];
                    OFS_IRQ_SET:   ien_ff <= ien_ff | wdata[2:0];
                    OFS_IRQ_CLR:   ien_ff <= ien_ff & ~wdata[2:0];
                    OFS_ENABLE:    enable_ff <= wdata[0];
                    OFS_CLKDIV:    div_ff <= wdata;
                    OFS_MODE:      mode_ff <= wdata[1:0];
                    OFS_GAIN_L:    gl_ff <= clamp_gain(wdata);
                    OFS_GAIN_R:    gr_ff <= clamp_gain(wdata);
                    OFS_RATIO:     ratio_ff <= wdata[0];
                    OFS_BUF_PTR:   ptr_ff <= wdata;
                    OFS_BUF_CNT:   cnt_ff <= wdata[CNT_W-1:0];
                    default: ;
                endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, interrupt, publish
    logic [31:0] rd_mux;
    always_comb
    begin
        case (addr)
            OFS_SUB_START: rd_mux = cfg_word(sen_ff[0], sch_ff[0]);
            OFS_SUB_STOP:  rd_mux = cfg_word(sen_ff[1], sch_ff[1]);
            OFS_EV_RUN:    rd_mux = {31'd0, ev_ff[0]};
            OFS_EV_HALT:   rd_mux = {31'd0, ev_ff[1]};
            OFS_EV_DONE:   rd_mux = {31'd0, ev_ff[2]};
            OFS_PUB_RUN:   rd_mux = cfg_word(pen_ff[0], pch_ff[0]);
            OFS_PUB_HALT:  rd_mux = cfg_word(pen_ff[1], pch_ff[1]);
            OFS_PUB_DONE:  rd_mux = cfg_word(pen_ff[2], pch_ff[2]);
            OFS_IRQ_EN, OFS_IRQ_SET, OFS_IRQ_CLR: rd_mux = {29'd0, ien_ff};
            OFS_ENABLE:    rd_mux = {31'd0, enable_ff};
            OFS_CLKDIV:    rd_mux = div_ff;
            OFS_MODE:      rd_mux = {30'd0, mode_ff};
            OFS_GAIN_L:    rd_mux = {25'd0, gl_ff};
            OFS_GAIN_R:    rd_mux = {25'd0, gr_ff};
            OFS_RATIO:     rd_mux = {31'd0, ratio_ff};
            OFS_BUF_PTR:   rd_mux = ptr_ff;
            OFS_BUF_CNT:   rd_mux = {17'd0, cnt_ff};
            default:       rd_mux = 32'h0000_0000;
        endcase
    end

    logic [CH_N-1:0] pub;
    always_comb
    begin
        pub = '0;
        for (int i = 0; i < 3; i++)
            if (pen_ff[i] && ev_set[i]) pub[pch_ff[i]] = 1'b1;
    end

    always_ff @(posedge clock or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
        begin
            rdata_ff <= 32'h0000_0000;
            irq_ff   <= 1'b0;
            chan_ff  <= '0;
        end
        else
        begin
            rdata_ff <= rd_stb ? rd_mux : 32'h0000_0000;
            irq_ff   <= |(nxt_ev & ien_ff);
            chan_ff  <= pub;
        end
    end

    assign rdata     = rdata_ff;
    assign irq       = irq_ff;
    assign chan_out  = chan_ff;
    assign mic_clock = mclk_ff;
endmodule : pmr_regs

/* verification/pmr_mic_model.sv */
`timescale 1ns/1ps
module pmr_mic_model #(
    parameter logic LEFT_LVL  = 1'b1,
    parameter logic RIGHT_LVL = 1'b0
)(
    input  wire logic mic_clock,
    output logic      mic_data
);
    initial mic_data = RIGHT_LVL;
    ////////////////////////////////////////////////////////////////////////////
    // left talks while clock high
    // Old level held 40 ns past each edge
    always @(mic_clock)
        mic_data <= #40 (mic_clock ? LEFT_LVL : RIGHT_LVL);
endmodule : pmr_mic_model

/* verification/pmr_regs_checker.sv */
`timescale 1ns/1ps
module pmr_regs_checker
    import pmr_pkg::*;
#(
    parameter int CH_N = 16
)(
    input wire logic            clock,
    input wire logic            rst_b,
    input wire logic [11:0]     addr,
    input wire logic [31:0]     wdata,
    input wire logic            wr_stb,
    input wire logic            rd_stb,
    input wire logic [31:0]     rdata,
    input wire logic [CH_N-1:0] chan_in,
    input wire logic [CH_N-1:0] chan_out,
    input wire logic            irq,
    input wire logic            mic_clock,
    input wire logic            mic_data,
    input wire logic            mem_we,
    input wire logic [31:0]     mem_addr,
    input wire logic [31:0]     mem_wdata
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_wr(logic [11:0] a);
        wr_stb && addr == a;
    endsequence
    sequence s_rd(logic [11:0] a);
        rd_stb && addr == a;
    endsequence
    chk_set_read:
    assert property (s_wr(OFS_IRQ_SET) ##0 wdata[2:0] == 3'h7 ##1 s_rd(OFS_IRQ_EN)
        |=> rdata[2:0] == 3'h7) else $error("irq set not read back");
    chk_set_zero:
    assert property (s_wr(OFS_IRQ_CLR) ##0 wdata[2:0] == 3'h7 ##1 s_wr(OFS_IRQ_SET)
        ##0 wdata == 32'h0 ##1 s_rd(OFS_IRQ_SET) |=> rdata[2:0] == 3'h0)
        else $error("zero write to set changed enables");
    chk_clr_irq:
    assert property (s_wr(OFS_IRQ_CLR) ##0 wdata[2:0] == 3'h7 |-> ##2 !irq)
        else $error("irq stays with all enables cleared");
    chk_gain_clamp:
    assert property (s_wr(OFS_GAIN_L) ##0 wdata > 32'h50 ##1 s_rd(OFS_GAIN_L)
        |=> rdata == 32'h0000_0050) else $error("gain not clamped");
    chk_gain_keep:
    assert property (s_wr(OFS_GAIN_L) ##0 wdata <= 32'h50 ##1 s_rd(OFS_GAIN_L)
        |=> rdata == $past(wdata, 2)) else $error("gain readback wrong");
    chk_disable_quiet:
    assert property (s_wr(OFS_ENABLE) ##0 !wdata[0] |-> ##2 (!mic_clock && !mem_we)[*4])
        else $error("activity after disable");
    chk_we_pulse:
    assert property (mem_we |=> !mem_we) else $error("memory write longer than a cycle");
    chk_rdata_idle:
    assert property (!$past(rd_stb) |-> rdata == 32'h0) else $error("read data outside slot");
endmodule : pmr_regs_checker

bind pmr_regs pmr_regs_checker #(.CH_N(CH_N)) i_chk (.clock(clock), .rst_b(rst_b),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .chan_in(chan_in), .chan_out(chan_out), .irq(irq), .mic_clock(mic_clock),
    .mic_data(mic_data), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

/* verification/pmr_regs_tb.sv */
`timescale 1ns/1ps
module pmr_regs_tb;
    import pmr_pkg::*;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic [15:0] chan_in = 16'h0;
    logic [31:0] rdata, mem_addr, mem_wdata, p, seed = 32'd46777;
    logic [15:0] chan_out;
    logic        irq, mic_clock, mic_data, mem_we, rd_d = 1'b0;
    logic [6:0]  v;
    logic [31:0] rd_q[$];
    logic [32:0] wq[$];
    int          num_errors = 0, checked = 0, pulses = 0, cyc = 0, n = 0;
    localparam logic [11:0] RA [15] = '{12'h100, 12'h104, 12'h108, 12'h180, 12'h184,
        12'h188, 12'h300, 12'h304, 12'h308, 12'h500, 12'h504, 12'h508, 12'h518, 12'h51c,
        12'h7fc};
    pmr_regs i_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .chan_in(chan_in),
        .chan_out(chan_out), .irq(irq), .mic_clock(mic_clock), .mic_data(mic_data),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));
    pmr_mic_model i_mic (.mic_clock(mic_clock), .mic_data(mic_data));
    initial
    begin
        forever #10 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic cmp(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %0t: got %h want %h", $time, g, e);
        end
    endtask : cmp
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge clock);
    endtask : rd
    task automatic idle(input int n);
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : idle
    task automatic wait_word(input logic mono, input logic [31:0] a);
        wq.push_back({mono, a});
        idle(1);
        while (wq.size() != 0)
            @(posedge clock);
    endtask : wait_word
    task automatic close_out;
        $display("errors %0d checked %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////////////
    // Result watcher
    always @(posedge clock)
    begin
        rd_d <= rd_stb;
        if (rd_d)
            cmp(rd_q.pop_front(), rdata);
        if (mem_we && wq.size() != 0)
        begin
            cmp(wq[0][31:0], mem_addr);
            cmp({31'h0, |mem_wdata[31:16]}, 32'h1);
            cmp({31'h0, |mem_wdata[15:0]}, {31'h0, wq[0][32]});
            void'(wq.pop_front());
        end
        if (chan_out[5])
            pulses++;
        cyc++;
        if (cyc == 50000)
        begin
            num_errors++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        for (int i = 0; i < 15; i++)
            rd(RA[i], RA[i] == OFS_CLKDIV ? CLKDIV_RST : (RA[i] == OFS_GAIN_L ||
                RA[i] == OFS_GAIN_R) ? {25'h0, GAIN_UNITY} : 32'h0);
        idle(2);
        $display("test 1 done");
        wr(OFS_IRQ_SET, 32'h0000_0007);
        rd(OFS_IRQ_EN, 32'h0000_0007);
        wr(OFS_IRQ_CLR, 32'h0000_0005);
        rd(OFS_IRQ_SET, 32'h0000_0002);
        rd(OFS_IRQ_CLR, 32'h0000_0002);
        wr(OFS_IRQ_EN, 32'h0000_0005);
        rd(OFS_IRQ_EN, 32'h0000_0005);
        wr(OFS_IRQ_CLR, 32'h0000_0007);
        wr(OFS_IRQ_SET, 32'h0000_0000);
        rd(OFS_IRQ_SET, 32'h0000_0000);
        cmp({31'h0, irq}, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 7'h7f : 7'(rnd());
            wr(OFS_GAIN_L, {25'h0, v});
            rd(OFS_GAIN_L, v > GAIN_CEILING ? 32'h50 : {25'h0, v});
        end
        wr(OFS_GAIN_R, 32'h0000_0010);
        rd(OFS_GAIN_R, 32'h0000_0010);
        rd(OFS_GAIN_L, v > GAIN_CEILING ? 32'h50 : {25'h0, v});
        wr(OFS_PUB_RUN, 32'h8000_0009);
        rd(OFS_PUB_RUN, 32'h8000_0009);
        idle(2);
        $display("test 2 done");
        p = {16'h2000, 16'(rnd()) & 16'hfffc};
        wr(OFS_GAIN_L, {25'h0, GAIN_UNITY});
        wr(OFS_CLKDIV, 32'h0A80_0000);
        wr(OFS_MODE, 32'h0000_0002);
        wr(OFS_ENABLE, 32'h0000_0001);
        wr(OFS_BUF_PTR, p);
        wr(OFS_BUF_CNT, 32'h0000_0004);
        wr(OFS_START, 32'h0000_0001);
        idle(2);
        rd(OFS_EV_RUN, 32'h0000_0001);
        idle(1);
        // One mic clock period at 1.3125 MHz: 38 to 39 system clocks
        while (mic_clock) @(posedge clock);
        while (!mic_clock) @(posedge clock);
        while (mic_clock)
        begin
            n++;
            @(posedge clock);
        end
        while (!mic_clock)
        begin
            n++;
            @(posedge clock);
        end
        cmp({31'h0, n >= 38 && n <= 39}, 32'h1);
        wait_word(1'b0, p);
        wait_word(1'b0, p + 32'h4);
        idle(3);
        rd(OFS_EV_DONE, 32'h0000_0001);
        wr(OFS_EV_DONE, 32'h0000_0000);
        rd(OFS_EV_DONE, 32'h0000_0000);
        rd(OFS_EV_HALT, 32'h0000_0000);
        wr(OFS_ENABLE, 32'h0000_0000);
        idle(8);
        $display("test 3 done");
        wr(OFS_MODE, 32'h0000_0001);
        wr(OFS_SUB_STOP, 32'h8000_0003);
        wr(OFS_ENABLE, 32'h0000_0001);
        wr(OFS_EV_HALT, 32'h0000_0000);
        wr(OFS_EV_DONE, 32'h0000_0000);
        wr(OFS_PUB_HALT, 32'h8000_0005);
        wr(OFS_IRQ_SET, 32'h0000_0002);
        wr(OFS_BUF_PTR, p + 32'h100);
        wr(OFS_START, 32'h0000_0001);
        pulses = 0;
        wait_word(1'b1, p + 32'h100);
        chan_in <= 16'h0008;
        @(posedge clock);
        chan_in <= 16'h0000;
        wait_word(1'b1, p + 32'h104);
        idle(4);
        rd(OFS_EV_HALT, 32'h0000_0001);
        rd(OFS_EV_DONE, 32'h0000_0001);
        idle(2);
        cmp({31'h0, irq}, 32'h1);
        cmp(pulses, 32'h1);
        wr(OFS_EV_HALT, 32'h0000_0000);
        idle(2);
        cmp({31'h0, irq}, 32'h0);
        $display("test 4 done");
        close_out();
    end
endmodule : pmr_regs_tb
